// >>> sdd_regs.vh
// register offsets, field positions, reset values and timing counts
`ifndef SDD_REGS_VH
`define SDD_REGS_VH
// word byte addresses on the avalon bus
`define SDD_ADDR_CTRL 4'h0
`define SDD_ADDR_NOTCH 4'h4
`define SDD_ADDR_STATUS 4'h8
`define SDD_ADDR_DATA 4'hC
// control fields
`define SDD_CTRL_GAIN_LSB 0
`define SDD_CTRL_GAIN_MSB 2
`define SDD_CTRL_POL_BIT 3
`define SDD_CTRL_BURN_BIT 4
// reset values: bipolar, gain 1, burn-out off
`define SDD_CTRL_RESET 8'h08
// notch code giving 30 Hz at 10 MHz: 10e6/(512*30) = 651
`define SDD_NOTCH_RESET 11'h28B
`define SDD_NOTCH_MIN 11'h00A
// modulator bit period in master clocks
`define SDD_MOD_DIV 8'd128
// decimation is notch code times 4 modulator samples
`define SDD_DEC_MUL 2
// conversion periods discarded after resync
`define SDD_SETTLE_CONV 3'd3
`define SDD_ACC_W 40
`endif

// >>> sdd_fifo.v
// synchronous fifo with valid/ready on both sides
`timescale 1ns/1ps
module sdd_fifo #(
  parameter WIDTH = 24,
  parameter DEPTH = 32,
  parameter AW = 5
) (
  input wire clk_sys,
  input wire rst,
  input wire ce,
  input wire flush,
  input wire in_valid,
  output wire in_ready,
  input wire [WIDTH-1:0] in_data,
  output wire out_valid,
  input wire out_ready,
  output wire [WIDTH-1:0] out_data
);
  reg [WIDTH-1:0] mem [0:DEPTH-1]; // storage array
  reg [AW:0] wp_ff; // write pointer with wrap bit
  reg [AW:0] rp_ff; // read pointer with wrap bit
  wire full = (wp_ff[AW] != rp_ff[AW]) && (wp_ff[AW-1:0] == rp_ff[AW-1:0]);
  wire empty = (wp_ff == rp_ff);
  wire do_wr = in_valid && !full;
  wire do_rd = out_ready && !empty;
  assign in_ready = !full;
  assign out_valid = !empty;
  assign out_data = mem[rp_ff[AW-1:0]];
  // data array write
  always @(posedge clk_sys) begin
    if (ce && do_wr) begin
      mem[wp_ff[AW-1:0]] <= in_data;
    end
  end
  // pointer update, flush empties the fifo
  always @(posedge clk_sys) begin
    if (rst) begin
      wp_ff <= {(AW+1){1'b0}};
      rp_ff <= {(AW+1){1'b0}};
    end else if (ce) begin
      if (flush) begin
        wp_ff <= {(AW+1){1'b0}};
        rp_ff <= {(AW+1){1'b0}};
      end else begin
        if (do_wr) begin
          wp_ff <= wp_ff + {{AW{1'b0}}, 1'b1};
        end
        if (do_rd) begin
          rp_ff <= rp_ff + {{AW{1'b0}}, 1'b1};
        end
      end
    end
  end
endmodule // sdd_fifo

// >>> sdd_cic3.v
// third-order cascaded integrator-comb decimator, no multipliers
`timescale 1ns/1ps
`include "sdd_regs.vh"
module sdd_cic3 (
  input wire clk_sys,
  input wire rst,
  input wire ce,
  input wire clear,
  input wire in_stb,
  input wire [`SDD_ACC_W-1:0] in_word,
  input wire [12:0] ratio,
  output reg out_stb,
  output reg [`SDD_ACC_W-1:0] out_word
);
  reg [`SDD_ACC_W-1:0] integ_ff [0:2]; // integrator chain
  reg [`SDD_ACC_W-1:0] comb_ff [0:2]; // comb delay taps
  reg [12:0] cnt_ff; // decimation counter
  reg [`SDD_ACC_W-1:0] c0;
  reg [`SDD_ACC_W-1:0] c1;
  reg [`SDD_ACC_W-1:0] c2;
  // comb differences formed from the integrator output
  always @* begin
    c0 = integ_ff[2] - comb_ff[0];
    c1 = c0 - comb_ff[1];
    c2 = c1 - comb_ff[2];
  end
  // integrators, decimation and combs; modular wrap keeps result exact
  always @(posedge clk_sys) begin
    if (rst || (ce && clear)) begin
      integ_ff[0] <= {`SDD_ACC_W{1'b0}};
      integ_ff[1] <= {`SDD_ACC_W{1'b0}};
      integ_ff[2] <= {`SDD_ACC_W{1'b0}};
      comb_ff[0] <= {`SDD_ACC_W{1'b0}};
      comb_ff[1] <= {`SDD_ACC_W{1'b0}};
      comb_ff[2] <= {`SDD_ACC_W{1'b0}};
      cnt_ff <= 13'h0000;
      out_stb <= 1'b0;
      out_word <= {`SDD_ACC_W{1'b0}};
    end else if (ce) begin
      out_stb <= 1'b0;
      if (in_stb) begin
        integ_ff[0] <= integ_ff[0] + in_word;
        integ_ff[1] <= integ_ff[1] + integ_ff[0];
        integ_ff[2] <= integ_ff[2] + integ_ff[1];
        if (cnt_ff >= ratio - 13'h0001) begin
          // one result per decimation period
          cnt_ff <= 13'h0000;
          comb_ff[0] <= integ_ff[2];
          comb_ff[1] <= c0;
          comb_ff[2] <= c1;
          out_word <= c2;
          out_stb <= 1'b1;
        end else begin
          cnt_ff <= cnt_ff + 13'h0001;
        end
      end
    end
  end
endmodule // sdd_cic3

// >>> sdd_top.v
// sigma-delta decimation path with avalon register slave
//
// Overview of operation
// - modulator bit sampled every 128 clocks
// - each bit widened to a 40-bit word
// - third-order cic decimator, no multipliers
// - 11-bit notch code sets decimation ratio
// - one output word per conversion period
// - response scales with rate, shape unchanged
// - settled data three to four periods later
// - datapath headroom beyond full scale
// - analog gains 1..8 by multiple sampling
// - gains 16..128 applied digitally in filter
// - gain is a written control field
// - polarity bit selects bipolar or unipolar
// - bipolar range double unipolar range
// - burn-out enable bit 4, off at reset
// - reset: bipolar, gain 1, 30 Hz notch
// - config write clears ready, resyncs filter
`timescale 1ns/1ps
`include "sdd_regs.vh"
module sdd_top (
  input wire clk_sys,
  input wire rst,
  input wire ce,
  input wire mod_bit,
  input wire [3:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_writedata,
  input wire [3:0] avs_byteenable,
  output reg [31:0] avs_readdata,
  output reg avs_waitrequest,
  output reg [2:0] front_gain_amp,
  output reg [3:0] front_sample_count,
  output reg burnout_source_enable,
  output reg result_ready_n
);
  // control state
  // all state below is frozen while ce is low, so a stalled clock
  // enable never loses a modulator sample or a half-finished access
  // a write to ctrl or notch restarts the filter from a clean state
  // results reach software only through the fifo and the data register
  reg [7:0] ctrl_ff; // gain, polarity, burn-out
  reg [10:0] notch_code_ff; // decimation code
  reg [7:0] div_ff; // modulator sampling divider
  reg mod_bit_ff; // captured modulator bit
  reg mod_stb_ff; // one clock per modulator sample
  reg resync_ff; // filter clear request
  reg [2:0] settle_ff; // outputs still to discard
  reg ack_ff; // bus answer phase
  reg pop_ff; // fifo read pulse
  reg overflow_ff; // sticky, result lost to full fifo
  wire cic_stb;
  wire [`SDD_ACC_W-1:0] cic_word;
  wire fifo_in_ready;
  wire fifo_out_valid;
  wire [23:0] fifo_out_data;
  reg [23:0] result;
  reg res_valid_ff;
  reg [23:0] res_word_ff;
  wire [2:0] gain_code = ctrl_ff[`SDD_CTRL_GAIN_MSB:`SDD_CTRL_GAIN_LSB];
  wire bipolar = ctrl_ff[`SDD_CTRL_POL_BIT];
  wire [12:0] ratio = {notch_code_ff, 2'b00};
  wire bus_req = (avs_read || avs_write) && !ack_ff;

  // number of front-end samples per modulator cycle for a gain code
  // gains above 8 keep the front end at 8 samples; the rest of the
  // gain is made up digitally, so the count needs four bits to hold 8
  function [3:0] samples_for;
    input [2:0] g;
    begin
      case (g)
        3'd0: samples_for = 4'd1;
        3'd1: samples_for = 4'd2;
        3'd2: samples_for = 4'd4;
        default: samples_for = 4'd8;
      endcase
    end
  endfunction

  // digital left shift for the high gains
  // codes 4..7 give x16..x128: one extra doubling per code step
  function [2:0] dig_shift;
    input [2:0] g;
    begin
      if (g > 3'd3) begin
        dig_shift = g - 3'd3;
      end else begin
        dig_shift = 3'd0;
      end
    end
  endfunction

  // modulator divider: sample the one-bit stream every 128 clocks
  // the divider free-runs and is not cleared on resync, so the first
  // result after a config write may come up to one bit period late
  // mod_stb_ff is a one-clock strobe that steps the integrators
  always @(posedge clk_sys) begin
    if (rst) begin
      div_ff <= 8'h00;
      mod_bit_ff <= 1'b0;
      mod_stb_ff <= 1'b0;
    end else if (ce) begin
      mod_stb_ff <= 1'b0;
      if (div_ff == `SDD_MOD_DIV - 8'd1) begin
        div_ff <= 8'h00;
        mod_bit_ff <= mod_bit;
        mod_stb_ff <= 1'b1;
      end else begin
        div_ff <= div_ff + 8'h01;
      end
    end
  end

  // bit to 40-bit word: +1 or -1; wide words give ample headroom
  // a one counts as plus one and a zero as minus one, so a stream of
  // half ones averages to zero and lands on mid-scale in bipolar coding
  wire [`SDD_ACC_W-1:0] mod_word = mod_bit_ff ?
    {{(`SDD_ACC_W-1){1'b0}}, 1'b1} : {`SDD_ACC_W{1'b1}};

  // decimator: ratio is four modulator samples per notch code step
  // clearing on resync means the old setup leaves nothing behind
  sdd_cic3 u_cic (
    .clk_sys(clk_sys),
    .rst(rst),
    .ce(ce),
    .clear(resync_ff),
    .in_stb(mod_stb_ff),
    .in_word(mod_word),
    .ratio(ratio),
    .out_stb(cic_stb),
    .out_word(cic_word)
  );

  // normalise cic gain (ratio^3) and apply digital gain and coding
  // the shift is three times the bits needed for the ratio; it is
  // exact when the ratio is a power of two and reads low otherwise
  // values beyond full scale clip instead of wrapping round the code
  // range, so an overdriven input never reads as the opposite end
  reg [63:0] scaled;
  reg [63:0] mag;
  reg [5:0] norm;
  reg signed [63:0] sval;
  always @* begin
    sval = {{24{cic_word[`SDD_ACC_W-1]}}, cic_word};
    // ratio^3 upper bound as power of two: shift by 3*ceil(log2)
    norm = 6'd0;
    if (ratio > 13'd4096) begin
      norm = 6'd39; // thirteen bits of ratio
    end else if (ratio > 13'd2048) begin
      norm = 6'd36; // twelve bits
    end else if (ratio > 13'd1024) begin
      norm = 6'd33; // eleven bits
    end else if (ratio > 13'd512) begin
      norm = 6'd30; // ten bits
    end else if (ratio > 13'd256) begin
      norm = 6'd27; // nine bits
    end else if (ratio > 13'd128) begin
      norm = 6'd24; // eight bits
    end else if (ratio > 13'd64) begin
      norm = 6'd21; // seven bits
    end else if (ratio > 13'd32) begin
      norm = 6'd18; // six bits
    end else begin
      norm = 6'd15; // below the usable code range
    end
    // bring to 24 bits signed: shift so full scale hits bit 23
    scaled = (sval <<< dig_shift(gain_code)) <<< 23;
    scaled = $signed(scaled) >>> norm;
    mag = scaled;
    if (bipolar) begin
      if (!mag[63] && (mag[62:23] != 40'h0)) begin
        // positive overrange clips to the top code
        result = 24'hFF_FFFF;
      end else if (mag[63] && (mag[62:23] != {40{1'b1}})) begin
        // negative overrange clips to the bottom code
        result = 24'h00_0000;
      end else begin
        // offset binary over twice the span
        result = {~scaled[23], scaled[22:0]};
      end
    end else if (mag[63]) begin
      result = 24'h00_0000;
    end else if (mag[62:23] != 40'h0) begin
      result = 24'hFF_FFFF;
    end else begin
      // unipolar: half the span mapped onto the full code range
      result = {mag[22:0], 1'b0};
    end
  end

  // drop outputs during settling, then queue results
  // the first three results after a resync come from a filter still
  // filling from its cleared state, so results reach the fifo from the fourth one on
  // a result that arrives while the last one still waits on a full fifo
  // is lost and the sticky overflow flag records it; a push accepted in the same cycle as a new
  // result lets the new result win the valid flag
  always @(posedge clk_sys) begin
    if (rst) begin
      settle_ff <= `SDD_SETTLE_CONV;
      res_valid_ff <= 1'b0;
      res_word_ff <= 24'h00_0000;
      overflow_ff <= 1'b0;
    end else if (ce) begin
      if (res_valid_ff && fifo_in_ready) begin
        res_valid_ff <= 1'b0;
      end
      if (resync_ff) begin
        settle_ff <= `SDD_SETTLE_CONV;
        res_valid_ff <= 1'b0;
      end else if (cic_stb) begin
        if (settle_ff != 3'd0) begin
          settle_ff <= settle_ff - 3'd1;
        end else if (res_valid_ff && !fifo_in_ready) begin
          overflow_ff <= 1'b1;
        end else begin
          res_valid_ff <= 1'b1;
          res_word_ff <= result;
        end
      end
    end
  end

  // result queue: flushed on resync so stale words never surface
  // software pops one word per data register read
  sdd_fifo #(
    .WIDTH(24),
    .DEPTH(32),
    .AW(5)
  ) u_fifo (
    .clk_sys(clk_sys),
    .rst(rst),
    .ce(ce),
    .flush(resync_ff),
    .in_valid(res_valid_ff),
    .in_ready(fifo_in_ready),
    .in_data(res_word_ff),
    .out_valid(fifo_out_valid),
    .out_ready(pop_ff),
    .out_data(fifo_out_data)
  );

  // avalon slave: one wait cycle, answer on the second cycle
  // a request is taken when seen with no answer pending; the answer
  // phase blocks a second take of the same held request
  // writes land at the taking edge, read data stands from that same
  // edge until the following read
  // ctrl and notch writes raise the resync strobe for one clock
  // unmapped reads return zero and unmapped writes are ignored
  always @(posedge clk_sys) begin
    if (rst) begin
      ctrl_ff <= `SDD_CTRL_RESET;
      notch_code_ff <= `SDD_NOTCH_RESET;
      resync_ff <= 1'b1;
      ack_ff <= 1'b0;
      pop_ff <= 1'b0;
      avs_readdata <= 32'h0000_0000;
      avs_waitrequest <= 1'b1;
    end else if (ce) begin
      resync_ff <= 1'b0;
      pop_ff <= 1'b0;
      ack_ff <= bus_req;
      avs_waitrequest <= !bus_req;
      if (bus_req && avs_write) begin
        case (avs_address)
          `SDD_ADDR_CTRL: begin
            if (avs_byteenable[0]) begin
              ctrl_ff <= avs_writedata[7:0];
              resync_ff <= 1'b1;
            end
          end
          `SDD_ADDR_NOTCH: begin
            if (avs_byteenable[0]) begin
              notch_code_ff[7:0] <= avs_writedata[7:0];
            end
            if (avs_byteenable[1]) begin
              notch_code_ff[10:8] <= avs_writedata[10:8];
            end
            if (avs_byteenable[1:0] != 2'b00) begin
              resync_ff <= 1'b1;
            end
          end
          default: begin
          end
        endcase
      end
      if (bus_req && avs_read) begin
        case (avs_address)
          `SDD_ADDR_CTRL: avs_readdata <= {24'h00_0000, ctrl_ff};
          `SDD_ADDR_NOTCH: avs_readdata <= {21'h00_0000, notch_code_ff};
          `SDD_ADDR_STATUS: begin
            avs_readdata <= {29'h0000_0000, overflow_ff,
              !fifo_in_ready, fifo_out_valid};
          end
          `SDD_ADDR_DATA: begin
            avs_readdata <= {8'h00, fifo_out_data};
            pop_ff <= fifo_out_valid;
          end
          default: avs_readdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  // pin outputs straight from flops
  // analog gain saturates at code 3; higher codes add digital gain
  // ready low means at least one word waits in the fifo; it goes high
  // on the pop so a reader does not see the same word announced twice
  always @(posedge clk_sys) begin
    if (rst) begin
      front_gain_amp <= 3'd0;
      front_sample_count <= 4'd1;
      burnout_source_enable <= 1'b0;
      result_ready_n <= 1'b1;
    end else if (ce) begin
      front_gain_amp <= (gain_code > 3'd3) ? 3'd3 : gain_code;
      front_sample_count <= samples_for(gain_code);
      burnout_source_enable <= ctrl_ff[`SDD_CTRL_BURN_BIT];
      result_ready_n <= resync_ff ? 1'b1 : !(fifo_out_valid && !pop_ff);
    end
  end
endmodule // sdd_top

// >>> sdd_top_chk.sv
// port checker for the decimation path
`timescale 1ns/1ps
module sdd_top_chk (
  input wire clk_sys,
  input wire rst,
  input wire [3:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_writedata,
  input wire [31:0] avs_readdata,
  input wire avs_waitrequest,
  input wire [2:0] front_gain_amp,
  input wire burnout_source_enable,
  input wire result_ready_n
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  // accepted write to control (0) or notch (4)
  wire cfg_wr = avs_write && !avs_waitrequest && avs_address[3] == 1'b0
    && avs_address[1:0] == 2'h0;
  wire ctl_wr = cfg_wr && !avs_address[2];
  reg [10:0] code_ff; // notch code in force
  reg [31:0] cnt_ff; // cycles since last resync
  reg seen_ff; // first result after resync already seen
  wire [31:0] per = {12'h000, code_ff, 9'h000}; // one conversion period
  // track code and resync time
  always @(posedge clk_sys) begin
    if (rst) begin
      code_ff <= 11'h28B;
      cnt_ff <= 32'h0000_0000;
      seen_ff <= 1'b0;
    end else begin
      cnt_ff <= cfg_wr ? 32'h0000_0000 : cnt_ff + 32'h0000_0001;
      seen_ff <= cfg_wr ? 1'b0 : (seen_ff | !result_ready_n);
      if (cfg_wr && avs_address[2])
        code_ff <= avs_writedata[10:0];
    end
  end
  sequence req_start;
    $rose(avs_read || avs_write);
  endsequence
  sequence answer_once;
    !avs_waitrequest ##1 avs_waitrequest;
  endsequence
  chk_bus_answer: assert property (req_start |=> answer_once)
    else $error("bus answer not one cycle after request");
  chk_wait_cause: assert property
    (!avs_waitrequest |-> $past(avs_read || avs_write))
    else $error("waitrequest low without request");
  chk_burn_follow: assert property (ctl_wr |-> ##2
    burnout_source_enable == $past(avs_writedata[4], 2))
    else $error("burn-out enable does not follow bit 4");
  chk_gain_split: assert property (ctl_wr |-> ##2 front_gain_amp ==
    {1'b0, $past(avs_writedata[1:0] | {2{avs_writedata[2]}}, 2)})
    else $error("front gain code wrong");
  chk_ready_resync: assert property (cfg_wr |-> ##2 result_ready_n)
    else $error("ready still low after config write");
  chk_settle_time: assert property
    ($fell(result_ready_n) && !seen_ff |-> cnt_ff >= 3 * per
    && cnt_ff <= 4 * per + 1024)
    else $error("first result outside three to four periods");
  chk_unmapped_rd: assert property (!avs_waitrequest && avs_read
    && avs_address[1:0] != 2'h0 |-> avs_readdata == 32'h0000_0000)
    else $error("unmapped read not zero");
  chk_reset_vals: assert property ($past(rst) |-> result_ready_n
    && !burnout_source_enable && front_gain_amp == 3'h0)
    else $error("outputs not at reset values");
endmodule // sdd_top_chk
bind sdd_top sdd_top_chk u_chk (.clk_sys(clk_sys), .rst(rst),
  .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
  .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
  .avs_waitrequest(avs_waitrequest), .front_gain_amp(front_gain_amp),
  .burnout_source_enable(burnout_source_enable),
  .result_ready_n(result_ready_n));

// >>> sdd_mod_model.sv
// modulator stand-in: one-bit stream of a set density
`timescale 1ns/1ps
module sdd_mod_model (
  input wire clk_sys,
  input wire rst,
  input wire [7:0] density,
  output reg mod_bit
);
  reg [6:0] div_ff; // clocks within one bit period
  reg [7:0] acc_ff; // first-order density accumulator
  wire [8:0] sum = {1'b0, acc_ff} + {1'b0, density}; // carry is the bit
  // one new bit every 128 master clocks
  always @(posedge clk_sys) begin
    if (rst) begin
      div_ff <= 7'h00;
      acc_ff <= 8'h00;
      mod_bit <= 1'b0;
    end else begin
      div_ff <= div_ff + 7'h01;
      if (div_ff == 7'h7F) begin
        acc_ff <= sum[7:0];
        mod_bit <= sum[8];
      end
    end
  end
endmodule // sdd_mod_model

// >>> sdd_top_tb_top.sv
// self-checking bench for the decimation path
`timescale 1ns/1ps
module sdd_top_tb_top;
  reg clk_sys, rst, avs_read, avs_write;
  reg [3:0] avs_address;
  reg [31:0] avs_writedata, rd;
  reg [7:0] density; // modulator ones density out of 256
  wire mod_bit, avs_waitrequest, burn, result_ready_n;
  wire [31:0] avs_readdata;
  wire [2:0] gain;
  wire [3:0] samples;
  integer failures, compares, cyc, t0, i;
  sdd_mod_model u_mod (.clk_sys(clk_sys), .rst(rst), .density(density),
    .mod_bit(mod_bit));
  sdd_top dut (.clk_sys(clk_sys), .rst(rst), .ce(1'b1), .mod_bit(mod_bit),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(4'hF),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .front_gain_amp(gain), .front_sample_count(samples),
    .burnout_source_enable(burn),
    .result_ready_n(result_ready_n));
  // 250 MHz clock
  initial begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end
  task complete_run;
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  // cycle count and hang limit
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 95000) begin
      failures = failures + 1;
      complete_run;
    end
  end
  task check_eq(input [31:0] got, input [31:0] exp);
    compares = compares + 1;
    if (got !== exp) begin
      failures = failures + 1;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task check_rng(input [31:0] got, input [31:0] lo, input [31:0] hi);
    compares = compares + 1;
    if ((got >= lo && got <= hi) !== 1'b1) begin
      failures = failures + 1;
      $display("Error at %0t: got %h range %h %h", $time, got, lo, hi);
    end
  endtask
  // bus write: hold until waitrequest sampled low
  task av_write(input [3:0] a, input [31:0] d);
    @(posedge clk_sys);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= 1'b1;
    @(posedge clk_sys);
    while (avs_waitrequest !== 1'b0) @(posedge clk_sys);
    avs_write <= 1'b0;
  endtask
  // bus read: data taken at the answering edge
  task av_read(input [3:0] a, output [31:0] d);
    @(posedge clk_sys);
    avs_address <= a;
    avs_read <= 1'b1;
    @(posedge clk_sys);
    while (avs_waitrequest !== 1'b0) @(posedge clk_sys);
    d = avs_readdata;
    avs_read <= 1'b0;
  endtask
  task wait_ready;
    while (result_ready_n !== 1'b0) @(posedge clk_sys);
  endtask
  initial begin
    failures = 0;
    compares = 0;
    cyc = 0;
    rst = 1'b1;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_address = 4'h0;
    avs_writedata = 32'h0000_0000;
    density = 8'h80;
    repeat (5) @(posedge clk_sys);
    rst <= 1'b0;
    @(posedge clk_sys);
    check_eq({31'h0, result_ready_n}, 32'h0000_0001);
    check_eq({31'h0, burn}, 32'h0000_0000);
    check_eq({28'h0, samples}, 32'h0000_0001);
    av_read(4'h0, rd);
    check_eq(rd, 32'h0000_0008);
    av_read(4'h4, rd);
    check_eq(rd, 32'h0000_028B);
    av_read(4'h2, rd);
    check_eq(rd, 32'h0000_0000);
    av_write(4'h6, 32'hFFFF_FFFF);
    av_read(4'h0, rd);
    check_eq(rd, 32'h0000_0008);
    // every gain code, burn-out toggled alongside
    for (i = 0; i < 8; i = i + 1) begin
      av_write(4'h0, {27'h0, i[0], 1'b1, i[2:0]});
      repeat (2) @(posedge clk_sys);
      check_eq({29'h0, gain}, (i > 3) ? 3 : i);
      check_eq({28'h0, samples}, (i > 3) ? 8 : (1 << i));
      check_eq({31'h0, burn}, {31'h0, i[0]});
      av_read(4'h0, rd);
      check_eq(rd, {27'h0, i[0], 1'b1, i[2:0]});
    end
    av_write(4'h0, 32'h0000_0000);
    av_read(4'h0, rd);
    check_eq(rd, 32'h0000_0000);
    av_write(4'h0, 32'h0000_0008);
    // code 16 gives ratio 64, where the power-of-two scaling is exact
    av_write(4'h4, 32'h0000_0010);
    t0 = cyc;
    wait_ready;
    check_rng(cyc - t0, 3 * 8192, 4 * 8192 + 1024);
    av_read(4'h8, rd);
    check_eq(rd, 32'h0000_0001);
    t0 = cyc;
    av_read(4'hC, rd);
    check_rng(rd, 32'h007E_0000, 32'h0082_0000);
    repeat (2) @(posedge clk_sys);
    wait_ready;
    check_rng(cyc - t0, 8192 - 16, 8192 + 16);
    density <= 8'hC0;
    // four reads after the step: the result already queued, then three more, the last one settled
    for (i = 0; i < 4; i = i + 1) begin
      wait_ready;
      av_read(4'hC, rd);
      repeat (2) @(posedge clk_sys);
    end
    check_rng(rd, 32'h00BC_0000, 32'h00C4_0000);
    complete_run;
  end
endmodule // sdd_top_tb_top
